// *** hdl/dpfp_fifo.v ***
// small flop-based fifo with valid/ready on both sides
`timescale 1ns/100ps
module dpfp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // fill side
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output wire in_ready_out,
  // drain side
  output wire out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input wire out_ready_in
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_idx;
  reg [AW-1:0] rd_idx;
  reg [AW:0] count;
  wire push;
  wire pop;
  integer i;

  // honest flags from the occupancy count
  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_idx];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // pointers wrap at depth, so depth need not be a power of two
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_idx <= {AW{1'b0}};
      rd_idx <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem[wr_idx] <= in_data_in;
        wr_idx <= (wr_idx == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rd_idx + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// *** hdl/dpfp_map.vh ***
// constants for the debug-port flash programming block
`ifndef DPFP_MAP_VH
`define DPFP_MAP_VH

// debug-link register addresses
`define DPFP_ADDR_PROG_CONTROL 8'h02
`define DPFP_ADDR_PROG_DATA 8'hb4

// reset values
`define DPFP_RST_SELECT 8'h00
`define DPFP_RST_PROG_CONTROL 8'h00
`define DPFP_RST_PROG_DATA 8'h00

// unlock codes, in order
`define DPFP_UNLOCK_FIRST 8'h02
`define DPFP_UNLOCK_SECOND 8'h01

// flash command bytes
`define DPFP_CMD_BLOCK_READ 8'h06
`define DPFP_CMD_BLOCK_WRITE 8'h07
`define DPFP_CMD_PAGE_ERASE 8'h08
`define DPFP_CMD_DEVICE_ERASE 8'h03

// operation codes toward the flash engine
`define DPFP_OP_BLOCK_READ 2'h0
`define DPFP_OP_BLOCK_WRITE 2'h1
`define DPFP_OP_PAGE_ERASE 2'h2
`define DPFP_OP_DEVICE_ERASE 2'h3

// link instruction field: bit 0 write, bit 1 address
`define DPFP_INS_DATA_READ 2'h0
`define DPFP_INS_DATA_WRITE 2'h1
`define DPFP_INS_ADDR_READ 2'h2
`define DPFP_INS_ADDR_WRITE 2'h3

// status byte returned by an address read
`define DPFP_STAT_OUT_READY 0
`define DPFP_STAT_IN_BUSY 1

// frame layout: 2 instruction edges, 8 data edges
`define DPFP_FRAME_LAST 4'h9

// link idle timeout
`define DPFP_CLK_MHZ 125
`define DPFP_LINK_IDLE_NS 4000
`define DPFP_LINK_IDLE_CYC ((`DPFP_LINK_IDLE_NS*`DPFP_CLK_MHZ+999)/1000)

`endif

// *** hdl/dpfp_top.v ***
// debug-link flash programming registers, pin sharing and flash sequencer
`timescale 1ns/100ps
`include "dpfp_map.vh"

// Behaviour
// - control register at link address 0x02, eight bits, resets to zero.
// - programming unlocks only after writing 0x02 then 0x01 to control.
// - once unlocked, programming stays enabled until system reset.
// - data register at 0xb4, eight bits, carries command, address, data.
// - data byte 0x06 means block read, 0x07 block write.
// - data byte 0x08 means page erase, 0x03 whole-device erase.
// - while halted, peripherals and software stay stalled; traffic then.
// - when halted, link takes clock/reset pin and data pin from user.
// - host selects target register first; data commands then use it.
module dpfp_top #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  // clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // core halt state
  input wire core_halt_req_in,
  output reg stall_out,
  // shared pins: link clock doubles as reset, link data two-way
  input wire debug_link_clock_in,
  input wire debug_link_data_in,
  output reg debug_link_data_out,
  output reg debug_link_data_oe_out,
  // user functions of the shared pins
  output reg user_rst_n_out,
  output reg user_data_in_out,
  input wire user_data_out_in,
  input wire user_data_oe_in,
  // flash engine
  output reg prog_enabled_out,
  output reg flash_op_valid_out,
  output reg [1:0] flash_op_out,
  output reg flash_data_valid_out,
  output reg [7:0] flash_data_out,
  input wire flash_data_ready_in,
  input wire flash_done_in,
  input wire flash_rdata_valid_in,
  input wire [7:0] flash_rdata_in
);

  localparam ST_CMD = 1'b0;
  localparam ST_ARG = 1'b1;
  localparam [11:0] IDLE_CYC = `DPFP_LINK_IDLE_CYC;

  // pin synchronisers and edge finder
  reg clk_s1, clk_s2, clk_s3;
  reg dat_s1, dat_s2;
  // link frame state
  reg [3:0] bit_cnt;
  reg [1:0] ins;
  reg [7:0] rx_shift, tx_shift;
  reg [11:0] idle_cnt;
  // registers
  reg [7:0] debug_register_select, flash_prog_control, flash_prog_data;
  reg unlock_armed, out_ready;
  // byte waiting to enter the fifo
  reg pend_valid;
  reg [7:0] pend_data;
  wire fifo_in_ready, fifo_out_valid;
  wire [7:0] fifo_out_data;
  reg fifo_out_ready;
  // sequencer
  reg seq_state, next_seq_state;
  wire [1:0] next_ins;
  wire link_rise, frame_end, wr_commit, rd_start;
  reg [7:0] rd_value;
  reg cmd_known;
  reg [1:0] cmd_op;

  ////////////////////////////////////////////////////////////////////
  // synchronisers: first stage feeds only the second
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
    end else begin
      clk_s1 <= debug_link_clock_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= debug_link_data_in;
      dat_s2 <= dat_s1;
    end
  end

  // link traffic counts only while halted
  assign link_rise = clk_s2 && !clk_s3 && stall_out;
  assign next_ins = {dat_s2, ins[0]};
  assign frame_end = link_rise && (bit_cnt == `DPFP_FRAME_LAST);
  assign wr_commit = frame_end && ins[0];
  assign rd_start = link_rise && (bit_cnt == 4'h1) && !ins[0]; // read

  ////////////////////////////////////////////////////////////////////
  // read value for the frame, chosen by instruction and selection
  always @* begin
    rd_value = 8'h00;
    if (next_ins == `DPFP_INS_ADDR_READ) begin
      rd_value[`DPFP_STAT_OUT_READY] = out_ready;
      rd_value[`DPFP_STAT_IN_BUSY] = pend_valid;
    end else if (debug_register_select == `DPFP_ADDR_PROG_CONTROL) begin
      rd_value = flash_prog_control;
    end else if (debug_register_select == `DPFP_ADDR_PROG_DATA) begin
      rd_value = flash_prog_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin sharing: user functions only while the core runs
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stall_out <= 1'b0;
      user_rst_n_out <= 1'b0;
      user_data_in_out <= 1'b0;
    end else begin
      stall_out <= core_halt_req_in;
      // halted: the clock pin no longer resets the core
      user_rst_n_out <= stall_out ? 1'b1 : clk_s2;
      user_data_in_out <= stall_out ? 1'b0 : dat_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link frame: 2 instruction bits then 8 data bits, lsb first
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_cnt <= 4'h0;
      ins <= 2'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      idle_cnt <= 12'h000;
      debug_link_data_out <= 1'b0;
      debug_link_data_oe_out <= 1'b0;
    end else if (!stall_out) begin
      bit_cnt <= 4'h0; // pin lent back to the user function
      idle_cnt <= 12'h000;
      debug_link_data_out <= user_data_out_in;
      debug_link_data_oe_out <= user_data_oe_in;
    end else if (link_rise) begin
      idle_cnt <= 12'h000;
      if (bit_cnt == 4'h0) begin
        ins[0] <= dat_s2;
        debug_link_data_oe_out <= 1'b0;
      end else if (bit_cnt == 4'h1) begin
        ins <= next_ins;
        if (rd_start) begin
          // first read bit goes out right after the instruction
          tx_shift <= {1'b0, rd_value[7:1]};
          debug_link_data_out <= rd_value[0];
          debug_link_data_oe_out <= 1'b1;
        end
      end else if (bit_cnt == `DPFP_FRAME_LAST) begin
        debug_link_data_oe_out <= 1'b0;
      end else begin
        rx_shift <= {dat_s2, rx_shift[7:1]};
        tx_shift <= {1'b0, tx_shift[7:1]};
        debug_link_data_out <= tx_shift[0];
      end
      bit_cnt <= frame_end ? 4'h0 : bit_cnt + 4'h1;
    end else if (idle_cnt == IDLE_CYC) begin
      // a stalled frame is dropped so the host can start over
      bit_cnt <= 4'h0;
      debug_link_data_oe_out <= 1'b0;
    end else begin
      idle_cnt <= idle_cnt + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers and unlock sequence
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      debug_register_select <= `DPFP_RST_SELECT;
      flash_prog_control <= `DPFP_RST_PROG_CONTROL;
      flash_prog_data <= `DPFP_RST_PROG_DATA;
      unlock_armed <= 1'b0;
      prog_enabled_out <= 1'b0;
      out_ready <= 1'b0;
      pend_valid <= 1'b0;
      pend_data <= 8'h00;
    end else begin
      if (wr_commit && ins[1]) begin
        debug_register_select <= {dat_s2, rx_shift[7:1]};
      end
      if (wr_commit && !ins[1] &&
          debug_register_select == `DPFP_ADDR_PROG_CONTROL) begin
        flash_prog_control <= {dat_s2, rx_shift[7:1]};
        // any other byte breaks the pair; only reset clears the enable
        unlock_armed <= ({dat_s2, rx_shift[7:1]} ==
          `DPFP_UNLOCK_FIRST);
        if (unlock_armed &&
            {dat_s2, rx_shift[7:1]} == `DPFP_UNLOCK_SECOND) begin
          prog_enabled_out <= 1'b1;
        end
      end
      // accepted byte leaves the holding slot when the fifo takes it
      if (pend_valid && fifo_in_ready) begin
        pend_valid <= 1'b0;
      end
      if (wr_commit && !ins[1] && prog_enabled_out && !pend_valid &&
          debug_register_select == `DPFP_ADDR_PROG_DATA) begin
        // busy host writes are dropped; host polls the busy flag
        pend_valid <= 1'b1;
        pend_data <= {dat_s2, rx_shift[7:1]};
        flash_prog_data <= {dat_s2, rx_shift[7:1]};
      end
      // read data from flash wins over the read that clears the flag
      if (rd_start && debug_register_select == `DPFP_ADDR_PROG_DATA &&
          !next_ins[1]) begin
        out_ready <= 1'b0;
      end
      if (flash_rdata_valid_in) begin
        out_ready <= 1'b1;
        flash_prog_data <= flash_rdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // command decode of the byte at the fifo head
  always @* begin
    cmd_known = 1'b1;
    cmd_op = `DPFP_OP_BLOCK_READ;
    case (fifo_out_data)
      `DPFP_CMD_BLOCK_READ: cmd_op = `DPFP_OP_BLOCK_READ;
      `DPFP_CMD_BLOCK_WRITE: cmd_op = `DPFP_OP_BLOCK_WRITE;
      `DPFP_CMD_PAGE_ERASE: cmd_op = `DPFP_OP_PAGE_ERASE;
      `DPFP_CMD_DEVICE_ERASE: cmd_op = `DPFP_OP_DEVICE_ERASE;
      default: cmd_known = 1'b0;
    endcase
  end

  // sequencer next state and fifo drain
  always @* begin
    next_seq_state = seq_state;
    fifo_out_ready = 1'b0;
    case (seq_state)
      ST_CMD: begin
        // unknown codes are consumed and discarded
        fifo_out_ready = 1'b1;
        if (fifo_out_valid && cmd_known) begin
          next_seq_state = ST_ARG;
        end
      end
      ST_ARG: begin
        fifo_out_ready = !flash_data_valid_out || flash_data_ready_in;
        if (flash_done_in) begin
          next_seq_state = ST_CMD;
        end
      end
      default: next_seq_state = ST_CMD;
    endcase
  end

  // sequencer outputs toward the flash engine
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seq_state <= ST_CMD;
      flash_op_valid_out <= 1'b0;
      flash_op_out <= `DPFP_OP_BLOCK_READ;
      flash_data_valid_out <= 1'b0;
      flash_data_out <= 8'h00;
    end else begin
      seq_state <= next_seq_state;
      flash_op_valid_out <= 1'b0;
      if (seq_state == ST_CMD && fifo_out_valid && cmd_known) begin
        flash_op_valid_out <= 1'b1;
        flash_op_out <= cmd_op;
      end
      if (seq_state == ST_ARG && fifo_out_valid && fifo_out_ready) begin
        flash_data_valid_out <= 1'b1;
        flash_data_out <= fifo_out_data;
      end else if (flash_data_ready_in) begin
        flash_data_valid_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // byte buffer between the link and the sequencer
  dpfp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(pend_valid),
    .in_data_in(pend_data),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_out_ready)
  );

endmodule

// *** tb/dpfp_chk.sv ***
// port assertions for the debug-link flash programming block
`timescale 1ns/100ps
module dpfp_chk (
  // clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // watched ports
  input wire core_halt_req_in,
  input wire stall_out,
  input wire user_rst_n_out,
  input wire user_data_in_out,
  input wire user_data_oe_in,
  input wire debug_link_data_oe_out,
  input wire prog_enabled_out,
  input wire flash_op_valid_out,
  input wire flash_data_valid_out,
  input wire [7:0] flash_data_out,
  input wire flash_data_ready_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////
  // halt and pin borrowing
  a_stall_follows_halt:
  assert property ($past(arst_n_in) |-> stall_out == $past(core_halt_req_in))
    else $error("stall does not follow halt request");
  a_reset_pin_borrowed:
  assert property (stall_out && $past(stall_out) |-> user_rst_n_out)
    else $error("user reset not held off while halted");
  a_data_pin_hidden:
  assert property (stall_out && $past(stall_out) |-> !user_data_in_out)
    else $error("user sees data pin while halted");
  // two past terms: mode switch may take a cycle either way
  a_user_owns_pin:
  assert property (!stall_out && !$past(stall_out) && !$past(stall_out, 2)
    |-> debug_link_data_oe_out == $past(user_data_oe_in))
    else $error("user drive of data pin not passed on");
  a_unlock_when_halted:
  assert property ($rose(prog_enabled_out) |-> stall_out)
    else $error("unlock outside halted state");
  ////////////////////////////////////////
  // programming state and flash engine side
  a_prog_sticky:
  assert property (prog_enabled_out |=> prog_enabled_out)
    else $error("programming mode left without reset");
  a_op_needs_unlock:
  assert property (flash_op_valid_out |-> prog_enabled_out)
    else $error("flash operation while locked");
  a_arg_needs_unlock:
  assert property (flash_data_valid_out |-> prog_enabled_out)
    else $error("flash data while locked");
  a_op_one_cycle:
  assert property (flash_op_valid_out |=> !flash_op_valid_out)
    else $error("operation strobe longer than one cycle");
  a_arg_held:
  assert property (flash_data_valid_out && !flash_data_ready_in
    |=> flash_data_valid_out && $stable(flash_data_out))
    else $error("flash data dropped before ready");
endmodule

bind dpfp_top dpfp_chk u_chk (
  .clk_in(clk_in),
  .arst_n_in(arst_n_in),
  .core_halt_req_in(core_halt_req_in),
  .stall_out(stall_out),
  .user_rst_n_out(user_rst_n_out),
  .user_data_in_out(user_data_in_out),
  .user_data_oe_in(user_data_oe_in),
  .debug_link_data_oe_out(debug_link_data_oe_out),
  .prog_enabled_out(prog_enabled_out),
  .flash_op_valid_out(flash_op_valid_out),
  .flash_data_valid_out(flash_data_valid_out),
  .flash_data_out(flash_data_out),
  .flash_data_ready_in(flash_data_ready_in)
);

// *** tb/dpfp_host.sv ***
// host programmer model driving the link clock and data pins
`timescale 1ns/100ps
module dpfp_host (
  // link pins
  output logic link_clock_out,
  output logic host_data_out,
  output logic host_oe_out,
  input wire logic wire_data_in
);
  // clock stands low between frames
  initial begin
    link_clock_out = 1'b0;
    host_data_out = 1'b0;
    host_oe_out = 1'b1;
  end
  // frame: two instruction bits, eight data bits lsb first
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
    output logic [7:0] rd);
    int k;
    rd = 8'h00;
    for (k = 0; k < 10; k++) begin
      host_data_out = (k < 2) ? ins[k] : wd[k-2];
      host_oe_out = (k < 2) || ins[0];
      #62.5 link_clock_out = 1'b1;
      #62.5 link_clock_out = 1'b0;
      if (!ins[0] && k >= 1 && k <= 8) rd[k-1] = wire_data_in;
    end
    host_oe_out = 1'b1;
    #250;
  endtask
  // a few clock pulses that never finish a frame
  task automatic part(input int n);
    repeat (n) begin
      host_data_out = 1'b1;
      #62.5 link_clock_out = 1'b1;
      #62.5 link_clock_out = 1'b0;
    end
    #250;
  endtask
endmodule

// *** tb/testbench.sv ***
// testbench for the debug-link flash programming block
`timescale 1ns/100ps
`include "dpfp_map.vh"
module testbench;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic halt = 1'b1;
  logic udo = 1'b0;
  logic udoe = 1'b0;
  logic rdy = 1'b0;
  logic done = 1'b0;
  logic rvld = 1'b0;
  logic [7:0] rdat = 8'h00;
  logic [7:0] rd, last_arg;
  logic [1:0] last_op;
  wire lclk, hd, hoe, dd, doe, wd, stall, urst, udi, prog, opv, dv;
  wire [1:0] op;
  wire [7:0] fd;
  int n_fail, samples_checked, n_ops, n_args;
  // released pin shows the inverse of the last device value
  assign wd = doe ? dd : (hoe ? hd : ~dd);
  dpfp_host host (.link_clock_out(lclk), .host_data_out(hd),
    .host_oe_out(hoe), .wire_data_in(wd));
  dpfp_top uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .core_halt_req_in(halt), .stall_out(stall),
    .debug_link_clock_in(lclk), .debug_link_data_in(wd),
    .debug_link_data_out(dd), .debug_link_data_oe_out(doe),
    .user_rst_n_out(urst), .user_data_in_out(udi),
    .user_data_out_in(udo), .user_data_oe_in(udoe),
    .prog_enabled_out(prog), .flash_op_valid_out(opv),
    .flash_op_out(op), .flash_data_valid_out(dv), .flash_data_out(fd),
    .flash_data_ready_in(rdy), .flash_done_in(done),
    .flash_rdata_valid_in(rvld), .flash_rdata_in(rdat));
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  // flash engine: one stall cycle before each ready
  always @(posedge clk_in) begin
    rdy <= dv && !rdy;
    if (opv === 1'b1) begin
      n_ops <= n_ops + 1;
      last_op <= op;
    end
    if (dv === 1'b1 && rdy) begin
      n_args <= n_args + 1;
      last_arg <= fd;
    end
  end
  ////////////////////////////////////////
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      n_fail++;
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic pulse_done();
    @(posedge clk_in);
    done <= 1'b1;
    @(posedge clk_in);
    done <= 1'b0;
  endtask
  task automatic pulse_rvld();
    @(posedge clk_in);
    rvld <= 1'b1;
    @(posedge clk_in);
    rvld <= 1'b0;
  endtask
  // status byte: bit 0 read data waiting, bit 1 write still pending
  task automatic st_chk(input logic [7:0] exp);
    host.frame(`DPFP_INS_ADDR_READ, 8'h00, rd);
    chk(exp, rd);
  endtask
  task automatic wait_chg(ref int c, input int base);
    int k;
    for (k = 0; k < 100 && c == base; k++) @(posedge clk_in);
    if (c == base) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic sel(input logic [7:0] a);
    host.frame(`DPFP_INS_ADDR_WRITE, a, rd);
  endtask
  task automatic wr(input logic [7:0] d);
    host.frame(`DPFP_INS_DATA_WRITE, d, rd);
  endtask
  task automatic rd_chk(input logic [7:0] exp);
    host.frame(`DPFP_INS_DATA_READ, 8'h00, rd);
    chk(exp, rd);
  endtask
  // poll status until the data register can take a byte
  task automatic wait_free();
    int k;
    for (k = 0; k < 20; k++) begin
      host.frame(`DPFP_INS_ADDR_READ, 8'h00, rd);
      if (rd[`DPFP_STAT_IN_BUSY] === 1'b0) return;
    end
    n_fail++;
    conclude();
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    sel(`DPFP_ADDR_PROG_CONTROL);
    rd_chk(`DPFP_RST_PROG_CONTROL);
    sel(`DPFP_ADDR_PROG_DATA);
    rd_chk(`DPFP_RST_PROG_DATA);
  endtask
  task automatic t_locked();
    wr(`DPFP_CMD_BLOCK_WRITE);
    ticks(20);
    chk(8'h00, n_ops[7:0]);
  endtask
  // codes out of order or a wrong second byte must not unlock
  task automatic t_unlock();
    sel(`DPFP_ADDR_PROG_CONTROL);
    wr(8'h01);
    wr(`DPFP_UNLOCK_FIRST);
    wr(8'h03);
    chk(8'h00, {7'h00, prog});
    wr(`DPFP_UNLOCK_FIRST);
    wr(`DPFP_UNLOCK_SECOND);
    ticks(2);
    chk(8'h01, {7'h00, prog});
    rd_chk(`DPFP_UNLOCK_SECOND);
  endtask
  task automatic t_cmds();
    logic [7:0] cmds [4];
    int i;
    int b;
    cmds = '{`DPFP_CMD_BLOCK_READ, `DPFP_CMD_BLOCK_WRITE,
      `DPFP_CMD_PAGE_ERASE, `DPFP_CMD_DEVICE_ERASE};
    sel(`DPFP_ADDR_PROG_DATA);
    // an unknown code is eaten without an operation
    wait_free();
    b = n_ops;
    wr(8'h55);
    ticks(10);
    chk(b[7:0], n_ops[7:0]);
    for (i = 0; i < 4; i++) begin
      wait_free();
      b = n_ops;
      wr(cmds[i]);
      wait_chg(n_ops, b);
      chk({6'h00, last_op}, i[7:0]);
      wait_free();
      b = n_args;
      wr(8'h40 + i[7:0]);
      wait_chg(n_args, b);
      chk(8'h40 + i[7:0], last_arg);
      pulse_done();
      if (i == 0) begin
        rdat <= 8'h5a;
        pulse_rvld();
        st_chk(8'h01);
        rd_chk(8'h5a);
        st_chk(8'h00);
      end
    end
  endtask
  // a frame cut short is dropped after the idle time
  task automatic t_idle();
    host.part(3);
    ticks(600);
    sel(`DPFP_ADDR_PROG_CONTROL);
    rd_chk(`DPFP_UNLOCK_SECOND);
  endtask
  task automatic t_pins();
    @(posedge clk_in);
    halt <= 1'b0;
    udo <= 1'b1;
    udoe <= 1'b1;
    ticks(6);
    chk(8'h00, {7'h00, stall});
    chk(8'h07, {5'h00, doe, dd, udi});
    chk(8'h01, {6'h00, urst, prog});
    halt <= 1'b1;
    udoe <= 1'b0;
    ticks(6);
    chk(8'h02, {6'h00, urst, udi});
    arst_n_in <= 1'b0;
    ticks(2);
    arst_n_in <= 1'b1;
    ticks(4);
    chk(8'h00, {7'h00, prog});
  endtask
  initial begin
    ticks(20);
    arst_n_in <= 1'b1;
    ticks(5);
    t_reset();
    t_locked();
    t_unlock();
    t_cmds();
    t_idle();
    t_pins();
    conclude();
  end
endmodule
